// >>> core/umsp_core.sv
`include "umsp_regs.svh"
module umsp_core
   import umsp_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   input  wire logic        port_out_val,
   input  wire logic        port_out_oe,
   output logic             serial_out_pin_o,
   output logic             serial_out_pin_oe,
   input  wire logic        serial_in_pin,
   output logic             serial_in_claimed,
   output logic             xfer_clock_pin_o,
   output logic             xfer_clock_pin_oe
);
   umsp_state_s q, d;
   logic        wr, rd, pop, tick, done, txclr, msm;
   logic [1:0]  n;
   logic [7:0]  sh;

   function automatic logic ofs_ok(input logic [7:0] a);
      ofs_ok = (a == `UMSP_OFS_DATA) || (a == `UMSP_OFS_STAT) ||
               (a == `UMSP_OFS_CTRL) || (a == `UMSP_OFS_FMT) ||
               (a == `UMSP_OFS_BAUD) || (a == `UMSP_OFS_PIN);
   endfunction

   // bit presented on the line for a given shift word
   function automatic logic line_bit(input logic [7:0] v, input logic lsb);
      line_bit = lsb ? v[0] : v[7];
   endfunction

   always_comb begin
      d     = q;
      wr    = 1'b0;
      rd    = 1'b0;
      pop   = 1'b0;
      tick  = 1'b0;
      done  = 1'b0;
      txclr = 1'b0;
      n     = q.rxn;
      sh    = q.tsr;
      msm   = (q.msel == `UMSP_MSEL_SPI);
      d.sync1 = serial_in_pin;
      d.sync2 = q.sync1;

      // write channel, address and data in either order
      if (s_axi_awvalid && q.awready) begin
         d.aw_v   = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wready) begin
         d.w_v   = 1'b1;
         d.wdata = s_axi_wdata[15:0];
         d.wstrb = s_axi_wstrb[1:0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_v && q.w_v && !q.bvalid) begin
         wr       = 1'b1;
         d.aw_v   = 1'b0;
         d.w_v    = 1'b0;
         d.bvalid = 1'b1;
         d.bresp  = ofs_ok(q.awaddr) ? `UMSP_RESP_OK : `UMSP_RESP_ERR;
         if (q.wstrb[0]) begin
            case (q.awaddr)
               `UMSP_OFS_DATA: begin
                  if (!q.txbv) begin
                     d.txbv  = 1'b1;
                     d.txbuf = q.wdata[7:0];
                  end
               end
               `UMSP_OFS_STAT: txclr = q.wdata[`UMSP_ST_TXC];
               `UMSP_OFS_CTRL: begin
                  d.rxen = q.wdata[`UMSP_CT_RXEN];
                  d.txen = q.wdata[`UMSP_CT_TXEN];
               end
               `UMSP_OFS_FMT: begin
                  d.msel = q.wdata[`UMSP_FM_MSEL];
                  d.ord  = q.wdata[`UMSP_FM_ORD];
                  d.pha  = q.wdata[`UMSP_FM_PHA];
                  d.pol  = q.wdata[`UMSP_FM_POL];
               end
               `UMSP_OFS_BAUD: d.baud[7:0] = q.wdata[7:0];
               `UMSP_OFS_PIN:  d.dir = q.wdata[0];
               default: ;
            endcase
         end
         if (q.wstrb[1] && q.awaddr == `UMSP_OFS_BAUD) begin
            d.baud[11:8] = q.wdata[11:8];
         end
      end
      d.awready = !d.aw_v && !d.bvalid;
      d.wready  = !d.w_v && !d.bvalid;

      // read channel
      if (s_axi_rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && q.arready) begin
         rd       = 1'b1;
         d.rvalid = 1'b1;
         d.rresp  = ofs_ok(s_axi_araddr) ? `UMSP_RESP_OK : `UMSP_RESP_ERR;
         d.rdata  = 8'h00;
         case (s_axi_araddr)
            `UMSP_OFS_DATA: begin
               d.rdata = q.rxb[0];
               pop     = (q.rxn != 2'h0);
            end
            `UMSP_OFS_STAT: begin
               // error flags stay zero in this mode
               d.rdata[`UMSP_ST_RXC]  = (q.rxn != 2'h0);
               d.rdata[`UMSP_ST_TXC]  = q.txc;
               d.rdata[`UMSP_ST_UDRE] = !q.txbv;
            end
            `UMSP_OFS_CTRL: begin
               d.rdata[`UMSP_CT_RXEN] = q.rxen;
               d.rdata[`UMSP_CT_TXEN] = q.txen;
            end
            `UMSP_OFS_FMT: begin
               d.rdata[`UMSP_FM_MSEL] = q.msel;
               d.rdata[`UMSP_FM_ORD]  = q.ord;
               d.rdata[`UMSP_FM_PHA]  = q.pha;
               d.rdata[`UMSP_FM_POL]  = q.pol;
            end
            `UMSP_OFS_BAUD: d.rdata = q.baud[7:0];
            `UMSP_OFS_PIN:  d.rdata = {7'h00, q.dir};
            default: ;
         endcase
      end
      d.arready = !d.rvalid;

      // transmitter stays active until shifter and buffer drain
      if (q.txen) begin
         d.txact = 1'b1;
      end else if (q.st == UMSP_IDLE && !q.txbv) begin
         d.txact = 1'b0;
      end

      // half-period divider, reloaded from the divisor
      if (q.st == UMSP_SHIFT) begin
         if (q.bcnt == 12'h000) begin
            tick   = 1'b1;
            d.bcnt = q.baud;
         end else begin
            d.bcnt = q.bcnt - 12'h001;
         end
      end

      sh = q.ord ? {1'b1, q.tsr[7:1]} : {q.tsr[6:0], 1'b1};
      case (q.st)
         UMSP_IDLE: begin
            d.sck = d.pol;
            d.txd = 1'b1;
         end
         UMSP_SHIFT: begin
            if (tick && q.lead) begin
               d.sck  = !q.pol;
               d.lead = 1'b0;
               if (!q.pha) begin
                  d.rsr = q.ord ? {q.sync2, q.rsr[7:1]} : {q.rsr[6:0], q.sync2};
               end else if (q.bitc != 3'h0) begin
                  d.tsr = sh;
                  d.txd = line_bit(sh, q.ord);
               end
            end else if (tick) begin
               d.sck  = q.pol;
               d.lead = 1'b1;
               d.bitc = q.bitc + 3'h1;
               if (q.pha) begin
                  d.rsr = q.ord ? {q.sync2, q.rsr[7:1]} : {q.rsr[6:0], q.sync2};
               end else if (q.bitc != `UMSP_FRAME_LAST) begin
                  d.tsr = sh;
                  d.txd = line_bit(sh, q.ord);
               end
               done = (q.bitc == `UMSP_FRAME_LAST);
            end
         end
         default: d.st = UMSP_IDLE;
      endcase

      if (done) begin
         d.st  = UMSP_IDLE;
         d.txd = 1'b1;
      end
      // shifter free: take the buffered byte, back to back if pending
      if ((q.st == UMSP_IDLE || done) && q.txbv && q.txact && msm) begin
         d.st   = UMSP_SHIFT;
         d.tsr  = q.txbuf;
         d.txd  = line_bit(q.txbuf, q.ord);
         d.txbv = 1'b0;
         d.bitc = 3'h0;
         d.lead = 1'b1;
         d.sck  = q.pol;
         d.bcnt = q.baud;
      end

      // transmit complete, set wins over software clear
      if (txclr) begin
         d.txc = 1'b0;
      end
      if (done && !q.txbv) begin
         d.txc = 1'b1;
      end

      // receive buffer: pop, then push
      if (pop) begin
         d.rxb[0] = q.rxb[1];
         d.rxb[1] = q.rxb[2];
         n        = q.rxn - 2'h1;
      end
      if (done && q.rxen) begin
         if (n == `UMSP_RX_DEPTH) begin
            d.rxb[2] = d.rsr;
         end else begin
            d.rxb[n] = d.rsr;
            n        = n + 2'h1;
         end
      end
      d.rxn = q.rxen ? n : 2'h0;

      // pin ownership
      d.pin_o  = d.txact ? d.txd : port_out_val;
      d.pin_oe = d.txact ? 1'b1 : port_out_oe;
      d.xck_o  = d.sck;
      d.xck_oe = q.dir;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q         <= '0;
         q.st      <= UMSP_IDLE;
         q.baud    <= `UMSP_BAUD_RST;
         q.lead    <= 1'b1;
         q.txd     <= 1'b1;
         q.pin_o   <= 1'b0;
         q.awready <= 1'b1;
         q.wready  <= 1'b1;
         q.arready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign s_axi_awready     = q.awready;
   assign s_axi_wready      = q.wready;
   assign s_axi_bvalid      = q.bvalid;
   assign s_axi_bresp       = q.bresp;
   assign s_axi_arready     = q.arready;
   assign s_axi_rvalid      = q.rvalid;
   assign s_axi_rresp       = q.rresp;
   assign s_axi_rdata       = {24'h000000, q.rdata};
   assign serial_out_pin_o  = q.pin_o;
   assign serial_out_pin_oe = q.pin_oe;
   assign serial_in_claimed = q.rxen;
   assign xfer_clock_pin_o  = q.xck_o;
   assign xfer_clock_pin_oe = q.xck_oe;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_idle_clk;
      (q.st == UMSP_IDLE) |-> (q.sck == q.pol);
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("clock not idle");

   property p_idle_line;
      (q.st == UMSP_IDLE) |-> q.txd;
   endproperty
   a_idle_line: assert property (p_idle_line) else $error("line not high");

   property p_frame_len;
      done |-> (q.bitc == `UMSP_FRAME_LAST) && !q.lead;
   endproperty
   a_frame_len: assert property (p_frame_len) else $error("bad frame length");

   property p_opposite;
      (tick && !done && (q.lead ^ q.pha)) |=> $stable(q.txd);
   endproperty
   a_opposite: assert property (p_opposite) else $error("data moved on sample");

   property p_lead_edge;
      (tick && q.lead && q.baud != 12'h000) |=> (q.sck != q.pol) ##1 (q.sck != q.pol);
   endproperty
   a_lead_edge: assert property (p_lead_edge) else $error("leading edge wrong");

   property p_pair;
      (done && q.txbv && q.txact && msm && !q.txc) |=> !q.txc && (q.st == UMSP_SHIFT);
   endproperty
   a_pair: assert property (p_pair) else $error("early complete");

   property p_tx_hold;
      (!q.txen && q.st == UMSP_SHIFT) |=> q.txact && q.pin_oe;
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("tx dropped early");

   property p_flush;
      !q.rxen |=> (q.rxn == 2'h0);
   endproperty
   a_flush: assert property (p_flush) else $error("rx not flushed");

   property p_overflow;
      (done && q.rxen && q.rxn == `UMSP_RX_DEPTH && !pop) |=>
         (q.rxb[0] == $past(q.rxb[0])) && (q.rxn == `UMSP_RX_DEPTH);
   endproperty
   a_overflow: assert property (p_overflow) else $error("old byte lost");

   property p_load;
      (q.st == UMSP_IDLE && q.txbv && q.txact && msm) |=>
         (q.st == UMSP_SHIFT) && !q.txbv && (q.txd == line_bit(q.tsr, q.ord));
   endproperty
   a_load: assert property (p_load) else $error("buffer not loaded");

   property p_no_mode;
      (q.st == UMSP_IDLE && !msm) |=> (q.st == UMSP_IDLE);
   endproperty
   a_no_mode: assert property (p_no_mode) else $error("frame without spi mode");

   property p_data_wr;
      (wr && q.wstrb[0] && q.awaddr == `UMSP_OFS_DATA && !q.txbv) |=> q.txbv;
   endproperty
   a_data_wr: assert property (p_data_wr) else $error("data write not buffered");

   property p_err_zero;
      (rd && s_axi_araddr == `UMSP_OFS_STAT) |=> (s_axi_rdata[4:0] == 5'h00);
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error flag set");

   c_back2back: cover property (done && q.txbv ##1 q.st == UMSP_SHIFT);
   c_overflow: cover property (done && q.rxn == `UMSP_RX_DEPTH);
   c_txc: cover property ($rose(q.txc));
   c_mode3: cover property (done && q.pha && q.pol);
   c_lsb_frame: cover property (done && q.ord);
endmodule

// >>> core/umsp_regs.svh
`ifndef UMSP_REGS_SVH
`define UMSP_REGS_SVH
// Summary of operation
// - Polarity 0: mode 0/1 sample rising/falling edge.
// - Polarity 1: mode 2/3 sample falling/rising edge.
// - Drive and capture on opposite clock edges.
// - Frames are exactly eight bits, no framing.
// - One bit order shared by transmit and receive.
// - Back-to-back frames allowed, else line idles high.
// - Two bytes queued; complete flag after second.
// - Receiver needs transmitter for the clock.
// - Divisor resets to zero for immediate clock.
// - Transmitter enable claims the serial output pin.
// - Receiver enable claims the serial input pin.
// - Clock pin carries the transfer clock.
// - Data register write starts every transfer.
// - Buffer enters shifter only when shifter free.
// - Overflow replaces newest byte, keeps older ones.
// - Frame, overrun, parity flags read zero.
// - Receive, transmit, empty flags behave normally.
// - Order one is LSB first, zero MSB first.
// - Master mode only with mode field 2'b11.
// - Transmitter disable waits for pending data.
// - Receiver disable flushes the receive buffer.
`define UMSP_OFS_DATA   8'h00
`define UMSP_OFS_STAT   8'h04
`define UMSP_OFS_CTRL   8'h08
`define UMSP_OFS_FMT    8'h0C
`define UMSP_OFS_BAUD   8'h10
`define UMSP_OFS_PIN    8'h14
`define UMSP_ST_RXC     7
`define UMSP_ST_TXC     6
`define UMSP_ST_UDRE    5
`define UMSP_CT_RXEN    4
`define UMSP_CT_TXEN    3
`define UMSP_FM_MSEL    7:6
`define UMSP_FM_ORD     2
`define UMSP_FM_PHA     1
`define UMSP_FM_POL     0
`define UMSP_MSEL_SPI   2'b11
`define UMSP_BAUD_RST   12'h000
`define UMSP_FRAME_LAST 3'h7
`define UMSP_RX_DEPTH   2'h3
`define UMSP_RESP_OK    2'b00
`define UMSP_RESP_ERR   2'b10
`endif

// >>> core/umsp_pkg.sv
package umsp_pkg;
   typedef enum logic [1:0] {
      UMSP_IDLE  = 2'b01,
      UMSP_SHIFT = 2'b10
   } umsp_state_e;
   typedef struct packed {
      umsp_state_e     st;
      logic            aw_v, w_v, awready, wready, bvalid;
      logic            arready, rvalid;
      logic [1:0]      bresp, rresp, wstrb;
      logic [7:0]      awaddr, rdata;
      logic [15:0]     wdata;
      logic            txen, rxen, dir, txact;
      logic [1:0]      msel;
      logic            ord, pha, pol;
      logic [11:0]     baud, bcnt;
      logic [7:0]      txbuf, tsr, rsr;
      logic            txbv, txc, lead, sck, txd;
      logic [2:0]      bitc;
      logic [2:0][7:0] rxb;
      logic [1:0]      rxn;
      logic            sync1, sync2;
      logic            pin_o, pin_oe, xck_o, xck_oe;
   } umsp_state_s;
endpackage

// >>> sim/umsp_spi_slave.sv
module umsp_spi_slave (
   input  wire logic       sck,
   input  wire logic       mosi,
   input  wire logic       pha,
   input  wire logic       lsb,
   input  wire logic       arm,
   input  wire logic [7:0] base,
   output logic            miso,
   output logic [7:0]      rx,
   output int              edges
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] p = 4'h0;
   logic [7:0] tx;
   logic [2:0] idx;
   logic       mosi_d;
   // line settles just after the clock edge, giving the sampler hold time
   assign #1 mosi_d = mosi;
   initial edges = 0;
   initial rx = 8'h00;
   // p counts clock edges within the frame, even values are leading edges
   always @(sck or posedge arm) begin
      if (arm) begin
         p = 4'h0;
         edges = 0;
      end else begin
         if (p[0] == pha)
            rx = lsb ? {mosi_d, rx[7:1]} : {rx[6:0], mosi_d};
         p = p + 4'h1;
         edges = edges + 1;
      end
   end
   // one byte per frame: base, base+1, ...
   assign tx = base + 8'(edges / 16);
   assign idx = (pha && p != 4'h0) ? 3'((p - 4'h1) >> 1) : p[3:1];
   assign miso = lsb ? tx[idx] : tx[3'h7 - idx];
endmodule

// >>> sim/usart_master_spi_mode_tb.sv
`include "umsp_regs.svh"
module usart_master_spi_mode_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awv = 1'b0;
   logic        wv = 1'b0;
   logic        arv = 1'b0;
   logic        pval = 1'b1;
   logic        poe = 1'b0;
   logic        arm = 1'b0;
   logic        s_pha = 1'b0;
   logic        s_lsb = 1'b0;
   logic [7:0]  awa = 8'h00;
   logic [7:0]  ara = 8'h00;
   logic [7:0]  s_base = 8'h00;
   logic [31:0] wd = 32'h0;
   logic [31:0] d;
   logic [1:0]  r;
   logic        awr, wrdy, bv, arr, rv, so, soe, claim, sck, sckoe, miso;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [7:0]  s_rx;
   int          s_edges;
   int          failures = 0;
   int          checks_done = 0;
   int          cycles = 0;

   umsp_core umsp_core_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
      .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
      .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_bresp(bresp),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
      .s_axi_rvalid(rv), .s_axi_rready(1'b1), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .port_out_val(pval), .port_out_oe(poe), .serial_out_pin_o(so), .serial_out_pin_oe(soe),
      .serial_in_pin(miso), .serial_in_claimed(claim), .xfer_clock_pin_o(sck), .xfer_clock_pin_oe(sckoe)
   );
   umsp_spi_slave umsp_spi_slave_i (.sck(sck), .mosi(so), .pha(s_pha), .lsb(s_lsb), .arm(arm),
      .base(s_base), .miso(miso), .rx(s_rx), .edges(s_edges));

   initial forever #2 aclk = ~aclk;

   always @(posedge aclk) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d, failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= v;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'b0;
         if (wrdy) wv <= 1'b0;
      end while (awv || wv);
      while (!bv) @(posedge aclk);
      r = bresp;
   endtask

   task automatic axr(input logic [7:0] a);
      arv <= 1'b1;
      ara <= a;
      do @(posedge aclk); while (!arr);
      arv <= 1'b0;
      do @(posedge aclk); while (!rv);
      d = rdata;
      r = rresp;
   endtask

   task automatic wait_st(input int b);
      do axr(`UMSP_OFS_STAT); while (d[b] !== 1'b1);
   endtask

   task automatic txdone();
      wait_st(`UMSP_ST_TXC);
      axw(`UMSP_OFS_STAT, 32'h40);
   endtask

   // restart the slave's edge count in the current mode
   task automatic go(input logic [7:0] f, input logic [7:0] b);
      s_pha <= f[`UMSP_FM_PHA];
      s_lsb <= f[`UMSP_FM_ORD];
      s_base <= b;
      arm <= 1'b1;
      @(posedge aclk);
      arm <= 1'b0;
   endtask

   task automatic t_reset();
      axr(`UMSP_OFS_STAT);
      chk(d, 32'h20);
      axr(`UMSP_OFS_BAUD);
      chk(d, 32'h0);
      axr(8'h18);
      chk(r, `UMSP_RESP_ERR);
      axw(8'h1C, 32'hFF);
      chk(r, `UMSP_RESP_ERR);
      chk({sck, sckoe, so, soe}, {2'b00, pval, poe});
      $display("test reset done");
   endtask

   task automatic t_init();
      axw(`UMSP_OFS_PIN, 32'h1);
      axw(`UMSP_OFS_FMT, 32'hC0);
      axw(`UMSP_OFS_CTRL, 32'h18);
      axw(`UMSP_OFS_BAUD, 32'h13);
      chk({sckoe, soe, claim, so, sck}, 5'h1E);
      $display("test init done");
   endtask

   task automatic t_modes();
      logic [7:0] f, t, b;
      for (int i = 0; i < 8; i++) begin
         f = {5'b11000, i[0], i[2], i[1]};
         t = 8'h96 + 8'h11 * 8'(i);
         b = 8'h2D + 8'h13 * 8'(i);
         axw(`UMSP_OFS_FMT, {24'h0, f});
         go(f, b);
         axw(`UMSP_OFS_DATA, {24'h0, t});
         txdone();
         chk(s_rx, t);
         chk(s_edges, 16);
         chk({sck, so}, {f[0], 1'b1});
         axr(`UMSP_OFS_DATA);
         chk(d, b);
      end
      $display("test modes done");
   endtask

   task automatic t_pair();
      axw(`UMSP_OFS_FMT, 32'hC4);
      go(8'hC4, 8'h71);
      axw(`UMSP_OFS_DATA, 32'h3A);
      axw(`UMSP_OFS_DATA, 32'hE5);
      axr(`UMSP_OFS_STAT);
      chk(d[7:5], 3'b000);
      txdone();
      chk(s_edges, 32);
      chk(s_rx, 8'hE5);
      axr(`UMSP_OFS_DATA);
      chk(d, 32'h71);
      axr(`UMSP_OFS_DATA);
      chk(d, 32'h72);
      $display("test pair done");
   endtask

   task automatic t_over();
      axw(`UMSP_OFS_FMT, 32'hC0);
      go(8'hC0, 8'h10);
      for (int i = 1; i < 5; i++) begin
         wait_st(`UMSP_ST_UDRE);
         axw(`UMSP_OFS_DATA, 32'(i));
      end
      txdone();
      chk(s_edges, 64);
      axr(`UMSP_OFS_DATA);
      chk(d, 32'h10);
      axr(`UMSP_OFS_DATA);
      chk(d, 32'h11);
      axr(`UMSP_OFS_DATA);
      chk(d, 32'h13);
      axr(`UMSP_OFS_STAT);
      chk(d[7], 1'b0);
      $display("test overflow done");
   endtask

   task automatic t_flush();
      go(8'hC0, 8'h55);
      axw(`UMSP_OFS_DATA, 32'hAA);
      txdone();
      axr(`UMSP_OFS_STAT);
      chk(d[7], 1'b1);
      axw(`UMSP_OFS_CTRL, 32'h08);
      axr(`UMSP_OFS_STAT);
      chk({d[7], claim}, 2'b00);
      axw(`UMSP_OFS_CTRL, 32'h18);
      $display("test flush done");
   endtask

   task automatic t_txoff();
      pval <= 1'b0;
      go(8'hC0, 8'h00);
      axw(`UMSP_OFS_DATA, 32'h5C);
      axw(`UMSP_OFS_CTRL, 32'h0);
      chk(soe, 1'b1);
      txdone();
      chk(s_rx, 8'h5C);
      chk({so, soe}, {pval, poe});
      axw(`UMSP_OFS_CTRL, 32'h10);
      go(8'hC0, 8'h00);
      axw(`UMSP_OFS_DATA, 32'h33);
      repeat (400) @(posedge aclk);
      chk(s_edges, 0);
      chk(claim, 1'b1);
      axw(`UMSP_OFS_FMT, 32'h80);
      axw(`UMSP_OFS_CTRL, 32'h18);
      repeat (400) @(posedge aclk);
      chk(s_edges, 0);
      $display("test disable done");
   endtask

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_init();
      t_modes();
      t_pair();
      t_over();
      t_flush();
      t_txoff();
      tally_and_finish();
   end
endmodule
